// file: hw/ief_map.vh
/*
 holds register offsets, field positions and reset values of the
 interrupt enable and flag logic; included by ief_top only.
*/
`ifndef IEF_MAP_VH
`define IEF_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IEF_OFS_MAIN 4'h0
`define IEF_OFS_PEN1 4'h4
`define IEF_OFS_PEN2 4'h8
`define IEF_OFS_PFLG1 4'hc
`define IEF_OFS_PFLG2 5'h10
`define IEF_OFS_PCHG 5'h14
`define IEF_OFS_CTRL 5'h18
`define IEF_OFS_ISTAT 5'h1c
`define IEF_OFS_IMASK 6'h20
// ----------------------------------------
// main control fields
// ----------------------------------------
`define IEF_GIE_BIT 7
`define IEF_PGATE_BIT 6
`define IEF_T0EN_BIT 5
`define IEF_EXTEN_BIT 4
`define IEF_PCEN_BIT 3
`define IEF_T0FLG_BIT 2
`define IEF_EXTFLG_BIT 1
`define IEF_PCFLG_BIT 0
// ----------------------------------------
// other fields and resets
// ----------------------------------------
`define IEF_PEN2_MASK 8'hef
`define IEF_MAIN_RST 8'h00
`define IEF_PEN_RST 8'h00
`define IEF_EDGE_BIT 0
`define IEF_VECTOR 16'h0004
`define IEF_PINS 8
`endif

// file: hw/ief_sync.v
/*
 two flip-flop synchroniser for a vector of pin levels.
 assumes one clock aclk and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ief_sync #(
	parameter W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
		end
	end
	assign dout = s2_q;
endmodule
`default_nettype wire

// file: hw/ief_edge.v
/*
 edge detector on synchronised pin levels, selectable polarity.
 assumes inputs already synchronised to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ief_edge #(
	parameter W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] lvl,
	input wire rise_sel,
	output wire [W-1:0] any_edge,
	output wire [W-1:0] sel_edge
);
	reg [W-1:0] prev_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= {W{1'b0}};
		end else begin
			prev_q <= lvl;
		end
	end
	assign any_edge = lvl ^ prev_q;
	// rising when select is one, falling otherwise
	assign sel_edge = rise_sel ? (lvl & ~prev_q) : (~lvl & prev_q);
endmodule
`default_nettype wire

// file: hw/ief_top.v
/*
 interrupt enable and flag logic: main control, two peripheral
 enable registers, flags and one request to the core, over AXI4-Lite.
 assumes event pulses from peripherals on aclk; pins asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ief_map.vh"
module ief_top #(
	parameter PINS = `IEF_PINS
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire timer0_overflow,
	input wire ext_pin,
	input wire [PINS-1:0] change_pins,
	input wire [7:0] periph_evt1,
	input wire [7:0] periph_evt2,
	input wire irq_taken,
	input wire return_from_service_op,
	output reg core_irq_q,
	output reg [15:0] core_vector_q,
	output reg irq_q
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [7:0] main_q;
	reg [7:0] pen1_q;
	reg [7:0] pen2_q;
	reg [7:0] pflg1_q;
	reg [7:0] pflg2_q;
	reg [PINS-1:0] per_pin_change_flags_q;
	reg ext_pin_edge_select_q;
	reg [2:0] istat_q;
	reg [2:0] imask_q;
	reg [31:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg aw_have_q;
	reg w_have_q;
	wire [PINS:0] pin_sync;
	wire [PINS-1:0] pc_any;
	wire [0:0] ext_sel;
	wire ext_edge;
	wire pin_change_summary_flag;
	wire wr_fire;
	wire rd_fire;
	wire [31:0] wmask;
	wire [31:0] wv;
	wire [7:0] w8;
	wire core_src;
	wire per_src;
	wire req_d;
	wire [2:0] ev;
	// ----------------------------------------
	// pin inputs
	// ----------------------------------------
	ief_sync #(.W(PINS + 1)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({ext_pin, change_pins}),
		.dout(pin_sync)
	);
	ief_edge #(.W(PINS)) u_pc_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(pin_sync[PINS-1:0]),
		.rise_sel(1'b1),
		.any_edge(pc_any),
		.sel_edge()
	);
	ief_edge #(.W(1)) u_ext_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(pin_sync[PINS]),
		.rise_sel(ext_pin_edge_select_q),
		.any_edge(),
		.sel_edge(ext_sel)
	);
	assign ext_edge = ext_sel[0];
	assign pin_change_summary_flag = |per_pin_change_flags_q;
	// ----------------------------------------
	// byte-lane write helper
	// ----------------------------------------
	function [31:0] lanes;
		input [3:0] s;
		begin
			lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction
	assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign wmask = lanes(wstrb_q);
	assign wv = wdata_q & wmask;
	assign w8 = wv[7:0];
	// ----------------------------------------
	// request logic
	// ----------------------------------------
	assign core_src = (main_q[`IEF_T0EN_BIT] & main_q[`IEF_T0FLG_BIT]) |
		(main_q[`IEF_EXTEN_BIT] & main_q[`IEF_EXTFLG_BIT]) |
		(main_q[`IEF_PCEN_BIT] & pin_change_summary_flag);
	assign per_src = main_q[`IEF_PGATE_BIT] &
		(|(pen1_q & pflg1_q) | |(pen2_q & pflg2_q));
	assign req_d = main_q[`IEF_GIE_BIT] & (core_src | per_src);
	assign ev = {irq_taken & core_irq_q, ext_edge, |pc_any};
	// ----------------------------------------
	// registers and flags
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			main_q <= `IEF_MAIN_RST;
			pen1_q <= `IEF_PEN_RST;
			pen2_q <= `IEF_PEN_RST;
			pflg1_q <= 8'h00;
			pflg2_q <= 8'h00;
			per_pin_change_flags_q <= {PINS{1'b0}};
			ext_pin_edge_select_q <= 1'b0;
			istat_q <= 3'h0;
			imask_q <= 3'h0;
			core_irq_q <= 1'b0;
			core_vector_q <= 16'h0000;
			irq_q <= 1'b0;
		end else begin
			if (wr_fire) begin
				if (awaddr_q[5:0] == {2'b00, `IEF_OFS_MAIN}) begin
					if (wstrb_q[0]) begin
						main_q[7:1] <= w8[7:1];
					end
				end else if (awaddr_q[5:0] == {2'b00, `IEF_OFS_PEN1}) begin
					if (wstrb_q[0]) begin
						pen1_q <= w8;
					end
				end else if (awaddr_q[5:0] == {2'b00, `IEF_OFS_PEN2}) begin
					if (wstrb_q[0]) begin
						pen2_q <= w8 & `IEF_PEN2_MASK;
					end
				end else if (awaddr_q[5:0] == {2'b00, `IEF_OFS_PFLG1}) begin
					pflg1_q <= pflg1_q & ~w8;
				end else if (awaddr_q[5:0] == {1'b0, `IEF_OFS_PFLG2}) begin
					pflg2_q <= pflg2_q & ~w8;
				end else if (awaddr_q[5:0] == {1'b0, `IEF_OFS_PCHG}) begin
					per_pin_change_flags_q <= per_pin_change_flags_q &
						~wv[PINS-1:0];
				end else if (awaddr_q[5:0] == {1'b0, `IEF_OFS_CTRL}) begin
					if (wstrb_q[0]) begin
						ext_pin_edge_select_q <= w8[`IEF_EDGE_BIT];
					end
				end else if (awaddr_q[5:0] == {1'b0, `IEF_OFS_ISTAT}) begin
					istat_q <= istat_q & ~w8[2:0];
				end else if (awaddr_q[5:0] == `IEF_OFS_IMASK) begin
					if (wstrb_q[0]) begin
						imask_q <= w8[2:0];
					end
				end
			end
			// set wins over a same-cycle clear
			if (timer0_overflow) begin
				main_q[`IEF_T0FLG_BIT] <= 1'b1;
			end
			if (ext_edge) begin
				main_q[`IEF_EXTFLG_BIT] <= 1'b1;
			end
			// core takes the request, gie cleared, vector loaded
			if (irq_taken & core_irq_q) begin
				main_q[`IEF_GIE_BIT] <= 1'b0;
				core_vector_q <= `IEF_VECTOR;
			end else if (return_from_service_op) begin
				main_q[`IEF_GIE_BIT] <= 1'b1;
			end
			pflg1_q[7:0] <= (wr_fire &&
				awaddr_q[5:0] == {2'b00, `IEF_OFS_PFLG1} ?
				pflg1_q & ~w8 : pflg1_q) | periph_evt1;
			pflg2_q <= ((wr_fire &&
				awaddr_q[5:0] == {1'b0, `IEF_OFS_PFLG2} ?
				pflg2_q & ~w8 : pflg2_q) | periph_evt2) &
				`IEF_PEN2_MASK;
			per_pin_change_flags_q <= ((wr_fire &&
				awaddr_q[5:0] == {1'b0, `IEF_OFS_PCHG}) ?
				per_pin_change_flags_q & ~wv[PINS-1:0] :
				per_pin_change_flags_q) | pc_any;
			istat_q <= ((wr_fire &&
				awaddr_q[5:0] == {1'b0, `IEF_OFS_ISTAT}) ?
				istat_q & ~w8[2:0] : istat_q) | ev;
			core_irq_q <= req_d & ~(irq_taken & core_irq_q);
			irq_q <= |(istat_q & imask_q);
		end
	end
	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q[31:6] == 26'h0 &&
					awaddr_q[1:0] == 2'b00 &&
					awaddr_q[5:2] <= 4'h8) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr[31:6] != 26'h0 ||
					s_axi_araddr[1:0] != 2'b00) begin
					s_axi_rresp <= 2'b10;
				end else if (s_axi_araddr[5:0] == {2'b00, `IEF_OFS_MAIN}) begin
					s_axi_rdata[7:0] <= {main_q[7:1],
						pin_change_summary_flag};
				end else if (s_axi_araddr[5:0] == {2'b00, `IEF_OFS_PEN1}) begin
					s_axi_rdata[7:0] <= pen1_q;
				end else if (s_axi_araddr[5:0] == {2'b00, `IEF_OFS_PEN2}) begin
					s_axi_rdata[7:0] <= pen2_q;
				end else if (s_axi_araddr[5:0] == {2'b00, `IEF_OFS_PFLG1}) begin
					s_axi_rdata[7:0] <= pflg1_q;
				end else if (s_axi_araddr[5:0] == {1'b0, `IEF_OFS_PFLG2}) begin
					s_axi_rdata[7:0] <= pflg2_q;
				end else if (s_axi_araddr[5:0] == {1'b0, `IEF_OFS_PCHG}) begin
					s_axi_rdata[PINS-1:0] <= per_pin_change_flags_q;
				end else if (s_axi_araddr[5:0] == {1'b0, `IEF_OFS_CTRL}) begin
					s_axi_rdata[0] <= ext_pin_edge_select_q;
				end else if (s_axi_araddr[5:0] == {1'b0, `IEF_OFS_ISTAT}) begin
					s_axi_rdata[2:0] <= istat_q;
				end else if (s_axi_araddr[5:0] == `IEF_OFS_IMASK) begin
					s_axi_rdata[2:0] <= imask_q;
				end else begin
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/ief_top_assertions.sv
/*
 checker on the ports of ief_top, bound into it.
 assumes one clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module ief_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_taken,
	input wire logic core_irq_q,
	input wire logic [15:0] core_vector_q,
	input wire logic irq_q
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_take;
		irq_taken && core_irq_q;
	endsequence
	sequence s_quiet;
		!core_irq_q && !irq_q && core_vector_q == 16'h0000;
	endsequence
	a_take_drop: assert property (s_take |=> !core_irq_q)
		else $error("request kept after take");
	a_take_vec: assert property (s_take |=> core_vector_q == 16'h0004)
		else $error("wrong vector after take");
	a_reset_quiet: assert property ($rose(aresetn) |-> s_quiet[*3])
		else $error("output active after reset");
	a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept after handshake");
	a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid kept after handshake");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready during response");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during read answer");
	a_r_cause: assert property ($rose(s_axi_rvalid) |->
		$past(s_axi_arvalid && s_axi_arready)) else $error("rvalid uncaused");
endmodule
bind ief_top ief_chk i_chk (.*);
`default_nettype wire

// file: test/ief_core_model.sv
/*
 core model: takes a request after lat cycles, returns 32 later.
 assumes aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module ief_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic core_irq_q,
	input wire logic [3:0] lat,
	output logic irq_taken,
	output logic return_from_service_op
);
	// ----------------------------------------
	// take and return
	// ----------------------------------------
	logic [4:0] cnt_q;
	logic busy_q;
	always @(posedge aclk) begin
		irq_taken <= 1'h0;
		return_from_service_op <= 1'h0;
		cnt_q <= cnt_q + 5'h1;
		if (!aresetn) begin
			busy_q <= 1'h0;
			cnt_q <= 5'h0;
		end else if (!busy_q && !core_irq_q) begin
			cnt_q <= 5'h0;
		end else if (!busy_q && cnt_q[3:0] == lat) begin
			irq_taken <= 1'h1;
			busy_q <= 1'h1;
			cnt_q <= 5'h0;
		end else if (busy_q && cnt_q == 5'h1f) begin
			return_from_service_op <= 1'h1;
			busy_q <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// file: test/test_irq_enable_flag_logic.sv
/*
 self-checking bench of the interrupt enable and flag logic.
 assumes ief_top, ief_core_model and the checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module test_irq_enable_flag_logic;
	// ----------------------------------------
	// bench
	// ----------------------------------------
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, timer0_overflow = 1'h0, ext_pin = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
	logic [7:0] change_pins = 8'h0, periph_evt1 = 8'h0, periph_evt2 = 8'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq_taken, return_from_service_op, core_irq_q, irq_q;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] core_vector_q;
	int failures = 0, cmp_count = 0;
	ief_top i_dut (.*);
	ief_core_model i_core (.*);
	always #12.5 aclk = ~aclk;
	task automatic end_of_test();
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic to();
		failures++;
		end_of_test();
	endtask
	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'h0);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) to();
		chk("bresp", s_axi_bresp, er);
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e,
		input logic [1:0] er = 2'h0);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) to();
		if (er == 2'h0) chk("rdata", s_axi_rdata, e);
		chk("rresp", s_axi_rresp, er);
	endtask
	task automatic wq(input logic v);
		int n;
		for (n = 0; n < 60 && core_irq_q !== v; n++) @(posedge aclk);
		if (n == 60) to();
		chk("core_irq_q", core_irq_q, v);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 3; i++) rc(i * 4, 32'h0);
		rc(32'h24, 32'h0, 2'h2);
		wr(32'h24, 32'h0, 2'h2);
		wr(32'h4, 32'hff);
		rc(32'h4, 32'hff);
		s_axi_wstrb <= 4'he;
		wr(32'h4, 32'h0);
		s_axi_wstrb <= 4'hf;
		rc(32'h4, 32'hff);
		wr(32'h8, 32'hff);
		rc(32'h8, 32'hef);
		wr(32'h0, 32'h39);
		rc(32'h0, 32'h38);
		$display("test regs done");
	endtask
	task automatic t_timer0();
		wr(32'h0, 32'h20);
		timer0_overflow <= 1'h1;
		cyc(1);
		timer0_overflow <= 1'h0;
		rc(32'h0, 32'h24);
		chk("core_irq_q", core_irq_q, 1'h0);
		wr(32'h0, 32'h20);
		wr(32'h0, 32'ha0);
		cyc(3);
		chk("core_irq_q", core_irq_q, 1'h0);
		timer0_overflow <= 1'h1;
		cyc(1);
		timer0_overflow <= 1'h0;
		wq(1'h1);
		wq(1'h0);
		chk("vector", core_vector_q, 32'h4);
		rc(32'h0, 32'h24);
		wr(32'h0, 32'h20);
		cyc(40);
		rc(32'h0, 32'ha0);
		wr(32'h0, 32'h0);
		$display("test timer0 done");
	endtask
	task automatic t_periph();
		lat <= 4'hf;
		wr(32'h0, 32'h80);
		periph_evt1 <= 8'h1;
		periph_evt2 <= 8'h11;
		cyc(1);
		periph_evt1 <= 8'h0;
		periph_evt2 <= 8'h0;
		rc(32'hc, 32'h1);
		rc(32'h10, 32'h1);
		chk("core_irq_q", core_irq_q, 1'h0);
		wr(32'h0, 32'hc0);
		wq(1'h1);
		wr(32'hc, 32'h1);
		chk("core_irq_q", core_irq_q, 1'h1);
		wr(32'h10, 32'h1);
		wq(1'h0);
		wr(32'h0, 32'h0);
		$display("test periph done");
	endtask
	task automatic t_ext();
		for (int s = 0; s < 2; s++) begin
			wr(32'h18, s);
			for (int p = 1; p >= 0; p--) begin
				wr(32'h0, 32'h0);
				ext_pin <= p[0];
				cyc(5);
				rc(32'h0, {30'h0, p[0] == s[0], 1'h0});
			end
		end
		$display("test ext done");
	endtask
	task automatic t_pins();
		wr(32'h1c, 32'h7);
		wr(32'h20, 32'h1);
		change_pins <= 8'h9;
		cyc(5);
		rc(32'h14, 32'h9);
		chk("irq_q", irq_q, 1'h1);
		wr(32'h14, 32'h1);
		rc(32'h0, 32'h1);
		wr(32'h14, 32'h8);
		wr(32'h1c, 32'h1);
		rc(32'h0, 32'h0);
		chk("irq_q", irq_q, 1'h0);
		wr(32'h20, 32'h0);
		change_pins <= 8'h0;
		cyc(5);
		rc(32'h1c, 32'h1);
		chk("irq_q", irq_q, 1'h0);
		$display("test pins done");
	endtask
	task automatic t_midrst();
		wr(32'h0, 32'hf8);
		aresetn <= 1'h0;
		cyc(2);
		aresetn <= 1'h1;
		cyc(1);
		for (int i = 0; i < 3; i++) rc(i * 4, 32'h0);
		$display("test reset done");
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		cyc(1);
		t_regs();
		t_timer0();
		t_periph();
		t_ext();
		t_pins();
		t_midrst();
		end_of_test();
	end
endmodule
`default_nettype wire
